// ===== design/i2c_regs_pkg.sv
// Purpose: Constants and carrier types for the I2C controller register bank
// Assumes: 32-bit APB, one aligned word per register
// Notes: Offsets are byte addresses
package i2c_regs_pkg;
    localparam logic [7:0] OFS_OWN_ADDR = 8'h00;
    localparam logic [7:0] OFS_INT_MASK = 8'h04;
    localparam logic [7:0] OFS_INT_STATUS = 8'h08;
    localparam logic [7:0] OFS_SCL_LOW = 8'h0c;
    localparam logic [7:0] OFS_SCL_HIGH = 8'h10;
    localparam logic [7:0] OFS_BYTE_COUNT = 8'h14;
    localparam logic [7:0] OFS_RX_DATA = 8'h18;
    localparam logic [7:0] OFS_TARGET_ADDR = 8'h1c;
    localparam logic [7:0] OFS_TX_DATA = 8'h20;
    localparam logic [7:0] OFS_MODE = 8'h24;
    localparam logic [7:0] OFS_VECTOR = 8'h28;
    localparam logic [7:0] OFS_EXT_MODE = 8'h2c;
    localparam logic [7:0] OFS_PRESCALER = 8'h30;
    localparam logic [7:0] OFS_REV_ONE = 8'h34;
    localparam logic [7:0] OFS_REV_TWO = 8'h38;
    localparam logic [7:0] OFS_PIN_FUNC = 8'h48;
    localparam logic [7:0] OFS_PIN_DIR = 8'h4c;
    localparam logic [7:0] OFS_PIN_IN = 8'h50;
    localparam logic [7:0] OFS_PIN_OUT = 8'h54;
    localparam logic [7:0] OFS_PIN_SET = 8'h58;
    localparam logic [7:0] OFS_PIN_CLR = 8'h5c;
    // Field widths and ten-bit mode bit position
    localparam int OWN_ADDR_W = 10;
    localparam int MASK_W = 7;
    localparam int STATUS_W = 15;
    localparam int BIT_XA = 8;
    // Status bit positions
    localparam int ST_ARB_LOST = 0;
    localparam int ST_NOACK = 1;
    localparam int ST_ACCESS_READY = 2;
    localparam int ST_RX_READY = 3;
    localparam int ST_TX_READY = 4;
    localparam int ST_STOP = 5;
    localparam int ST_ADDRESSED = 9;
    localparam int ST_OVERRUN = 11;
    localparam int ST_SHIFT_EMPTY = 10;
    localparam int ST_ZERO_ADDR = 8;
    localparam int ST_BUS_BUSY = 12;
    localparam int ST_NOACK_SENT = 13;
    localparam int ST_SLAVE_TX = 14;
    localparam logic [14:0] STATUS_W1C_MASK = 15'h703f;
    localparam logic [14:0] STATUS_RO_MASK = 15'h0f00;
    localparam logic [14:0] STATUS_RESET = 15'h0410;
    localparam logic [31:0] REV_ONE_VALUE = 32'h0000_0001; // Arbitrary value
    localparam logic [31:0] REV_TWO_VALUE = 32'h0000_0000; // Arbitrary value
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // Event pulses from the bus engine
    typedef struct packed {
        logic slave_tx_direction;
        logic noack_sent;
        logic bus_busy_flag;
        logic stop_detected;
        logic tx_data_ready;
        logic rx_data_ready;
        logic access_ready;
        logic noack;
        logic arbitration_lost;
    } event_t;

    // Levels from the bus engine
    typedef struct packed {
        logic rx_overrun;
        logic tx_shift_empty_n;
        logic addressed_as_slave;
        logic zero_address_seen;
    } level_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_resp_t;
endpackage

// ===== design/i2c_ctrl_register_bank.sv
// Purpose: APB register bank of an I2C controller
// Assumes: Events and levels arrive on i_clock from the bus engine
// Notes: Zero wait-state slave; unmapped offsets read zero
//
// Function
// - Registers decode at fixed byte offsets 0h to 5Ch, gap 3Ch-44h.
// - Seven-bit mode matches own address on bits 6-0 only.
// - Ten-bit mode matches own address on bits 9-0.
// - Reserved bits of address, mask, status read zero and ignore writes.
// - Mask bits 5 to 0 enable status flags 5-0; bit 6 enables addressed-as-slave.
// - Status reports flags at bits 14-8 and 5-0.
// - Bits 14-12 and 5-0 clear on write one; others read only.
// - After reset shift-empty and transmit-ready read one, others zero.
// - Events set flags; interrupt forwarded only where mask bit is one.
// - Addressed-as-slave raised on own address match or the engine's addressed level.
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module i2c_ctrl_register_bank (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire i2c_regs_pkg::event_t i_event,
    input wire i2c_regs_pkg::level_t i_level,
    input wire logic i_addr_valid,
    input wire logic [9:0] i_rx_addr,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_byte_valid,
    input wire logic [7:0] i_pin_in,
    output logic o_addr_match,
    output logic o_irq,
    output logic [31:0] o_mode,
    output logic [31:0] o_tx_data
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [9:0] own_addr_field;
        logic [6:0] mask;
        logic [14:0] status;
        logic [31:0] scl_low;
        logic [31:0] scl_high;
        logic [31:0] count;
        logic [7:0] rx_data;
        logic [31:0] target;
        logic [31:0] tx_data;
        logic [31:0] mode;
        logic [31:0] ext_mode;
        logic [31:0] prescaler;
        logic [31:0] pin_func;
        logic [31:0] pin_dir;
        logic [31:0] pin_out;
        logic [7:0] pin_in_meta;
        logic [7:0] pin_in_sync;
        i2c_regs_pkg::apb_resp_t resp;
        logic irq;
        logic addr_match;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic setup;
    logic wr;
    logic [31:0] wmask;
    logic [31:0] rd;
    logic [14:0] w1c;
    logic [14:0] set_bits;
    logic [14:0] lvl_bits;
    logic ten_bit_addressing_sel;
    logic match;
    logic [9:0] own_merged;
    logic [6:0] mask_merged;
    logic [31:0] scl_low_merged;
    logic [31:0] scl_high_merged;
    logic [31:0] count_merged;
    logic [31:0] target_merged;
    logic [31:0] tx_data_merged;
    logic [31:0] mode_merged;
    logic [31:0] ext_mode_merged;
    logic [31:0] prescaler_merged;
    logic [31:0] pin_func_merged;
    logic [31:0] pin_dir_merged;
    logic [31:0] pin_out_merged;

    // ------------------------------------------------------------
    // Byte-lane merge of writable registers
    // ------------------------------------------------------------
    i2c_lane_merge #(
        .WIDTH(10)
    ) merge_own (
        .i_old(cur.own_addr_field),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(own_merged)
    );

    i2c_lane_merge #(
        .WIDTH(7)
    ) merge_mask (
        .i_old(cur.mask),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(mask_merged)
    );

    i2c_lane_merge #(
        .WIDTH(32)
    ) merge_scl_low (
        .i_old(cur.scl_low),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(scl_low_merged)
    );

    i2c_lane_merge #(
        .WIDTH(32)
    ) merge_scl_high (
        .i_old(cur.scl_high),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(scl_high_merged)
    );

    i2c_lane_merge #(
        .WIDTH(32)
    ) merge_count (
        .i_old(cur.count),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(count_merged)
    );

    i2c_lane_merge #(
        .WIDTH(32)
    ) merge_target (
        .i_old(cur.target),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(target_merged)
    );

    i2c_lane_merge #(
        .WIDTH(32)
    ) merge_tx_data (
        .i_old(cur.tx_data),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(tx_data_merged)
    );

    i2c_lane_merge #(
        .WIDTH(32)
    ) merge_mode (
        .i_old(cur.mode),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(mode_merged)
    );

    i2c_lane_merge #(
        .WIDTH(32)
    ) merge_ext_mode (
        .i_old(cur.ext_mode),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(ext_mode_merged)
    );

    i2c_lane_merge #(
        .WIDTH(32)
    ) merge_prescaler (
        .i_old(cur.prescaler),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(prescaler_merged)
    );

    i2c_lane_merge #(
        .WIDTH(32)
    ) merge_pin_func (
        .i_old(cur.pin_func),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(pin_func_merged)
    );

    i2c_lane_merge #(
        .WIDTH(32)
    ) merge_pin_dir (
        .i_old(cur.pin_dir),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(pin_dir_merged)
    );

    i2c_lane_merge #(
        .WIDTH(32)
    ) merge_pin_out (
        .i_old(cur.pin_out),
        .i_wdata(i_pwdata),
        .i_strb(i_pstrb),
        .o_merged(pin_out_merged)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        setup = i_psel && !i_penable;
        wr = i_psel && i_penable && i_pwrite && cur.resp.pready;
        wmask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
        ten_bit_addressing_sel = cur.mode[i2c_regs_pkg::BIT_XA];
        // Own address compare
        if (ten_bit_addressing_sel) begin
            match = (i_rx_addr == cur.own_addr_field);
        end else begin
            match = (i_rx_addr[6:0] == cur.own_addr_field[6:0]);
        end
        next_cur.addr_match = i_addr_valid && match;

        // Synchroniser for pin input
        next_cur.pin_in_meta = i_pin_in;
        next_cur.pin_in_sync = cur.pin_in_meta;

        // Status: set events, levels, write one to clear
        w1c = '0;
        if (wr && i_paddr == i2c_regs_pkg::OFS_INT_STATUS) begin
            w1c = i_pwdata[14:0] & wmask[14:0] & i2c_regs_pkg::STATUS_W1C_MASK;
        end
        set_bits = '0;
        set_bits[i2c_regs_pkg::ST_ARB_LOST] = i_event.arbitration_lost;
        set_bits[i2c_regs_pkg::ST_NOACK] = i_event.noack;
        set_bits[i2c_regs_pkg::ST_ACCESS_READY] = i_event.access_ready;
        set_bits[i2c_regs_pkg::ST_RX_READY] = i_event.rx_data_ready;
        set_bits[i2c_regs_pkg::ST_TX_READY] = i_event.tx_data_ready;
        set_bits[i2c_regs_pkg::ST_STOP] = i_event.stop_detected;
        set_bits[i2c_regs_pkg::ST_BUS_BUSY] = i_event.bus_busy_flag;
        set_bits[i2c_regs_pkg::ST_NOACK_SENT] = i_event.noack_sent;
        set_bits[i2c_regs_pkg::ST_SLAVE_TX] = i_event.slave_tx_direction;
        lvl_bits = '0;
        lvl_bits[i2c_regs_pkg::ST_OVERRUN] = i_level.rx_overrun;
        lvl_bits[i2c_regs_pkg::ST_SHIFT_EMPTY] = i_level.tx_shift_empty_n;
        lvl_bits[i2c_regs_pkg::ST_ZERO_ADDR] = i_level.zero_address_seen;
        lvl_bits[i2c_regs_pkg::ST_ADDRESSED] = i_level.addressed_as_slave
            || cur.addr_match;
        // Set wins over clear
        next_cur.status = ((cur.status & ~w1c) | set_bits)
            & i2c_regs_pkg::STATUS_W1C_MASK;
        next_cur.status = next_cur.status | lvl_bits;

        if (i_rx_byte_valid) begin
            next_cur.rx_data = i_rx_byte;
        end

        // Register writes
        if (wr) begin
            unique case (i_paddr)
                i2c_regs_pkg::OFS_OWN_ADDR: begin
                    next_cur.own_addr_field = own_merged;
                end
                i2c_regs_pkg::OFS_INT_MASK: begin
                    next_cur.mask = mask_merged;
                end
                i2c_regs_pkg::OFS_SCL_LOW: begin
                    next_cur.scl_low = scl_low_merged;
                end
                i2c_regs_pkg::OFS_SCL_HIGH: begin
                    next_cur.scl_high = scl_high_merged;
                end
                i2c_regs_pkg::OFS_BYTE_COUNT: begin
                    next_cur.count = count_merged;
                end
                i2c_regs_pkg::OFS_TARGET_ADDR: begin
                    next_cur.target = target_merged;
                end
                i2c_regs_pkg::OFS_TX_DATA: begin
                    next_cur.tx_data = tx_data_merged;
                end
                i2c_regs_pkg::OFS_MODE: begin
                    next_cur.mode = mode_merged;
                end
                i2c_regs_pkg::OFS_EXT_MODE: begin
                    next_cur.ext_mode = ext_mode_merged;
                end
                i2c_regs_pkg::OFS_PRESCALER: begin
                    next_cur.prescaler = prescaler_merged;
                end
                i2c_regs_pkg::OFS_PIN_FUNC: begin
                    next_cur.pin_func = pin_func_merged;
                end
                i2c_regs_pkg::OFS_PIN_DIR: begin
                    next_cur.pin_dir = pin_dir_merged;
                end
                i2c_regs_pkg::OFS_PIN_OUT: begin
                    next_cur.pin_out = pin_out_merged;
                end
                i2c_regs_pkg::OFS_PIN_SET: begin
                    next_cur.pin_out = cur.pin_out | (i_pwdata & wmask);
                end
                i2c_regs_pkg::OFS_PIN_CLR: begin
                    next_cur.pin_out = cur.pin_out & ~(i_pwdata & wmask);
                end
                default: begin
                    next_cur.mode = cur.mode;
                end
            endcase
        end

        // Read mux
        unique case (i_paddr)
            i2c_regs_pkg::OFS_OWN_ADDR: rd = {22'h0, cur.own_addr_field};
            i2c_regs_pkg::OFS_INT_MASK: rd = {25'h0, cur.mask};
            i2c_regs_pkg::OFS_INT_STATUS: rd = {17'h0, cur.status};
            i2c_regs_pkg::OFS_SCL_LOW: rd = cur.scl_low;
            i2c_regs_pkg::OFS_SCL_HIGH: rd = cur.scl_high;
            i2c_regs_pkg::OFS_BYTE_COUNT: rd = cur.count;
            i2c_regs_pkg::OFS_RX_DATA: rd = {24'h0, cur.rx_data};
            i2c_regs_pkg::OFS_TARGET_ADDR: rd = cur.target;
            i2c_regs_pkg::OFS_TX_DATA: rd = cur.tx_data;
            i2c_regs_pkg::OFS_MODE: rd = cur.mode;
            i2c_regs_pkg::OFS_VECTOR: rd = i2c_regs_pkg::ZERO_WORD;
            i2c_regs_pkg::OFS_EXT_MODE: rd = cur.ext_mode;
            i2c_regs_pkg::OFS_PRESCALER: rd = cur.prescaler;
            i2c_regs_pkg::OFS_REV_ONE: rd = i2c_regs_pkg::REV_ONE_VALUE;
            i2c_regs_pkg::OFS_REV_TWO: rd = i2c_regs_pkg::REV_TWO_VALUE;
            i2c_regs_pkg::OFS_PIN_FUNC: rd = cur.pin_func;
            i2c_regs_pkg::OFS_PIN_DIR: rd = cur.pin_dir;
            i2c_regs_pkg::OFS_PIN_IN: rd = {24'h0, cur.pin_in_sync};
            i2c_regs_pkg::OFS_PIN_OUT: rd = cur.pin_out;
            default: rd = i2c_regs_pkg::ZERO_WORD;
        endcase

        // One wait-free access phase: answer registered in setup
        next_cur.resp.pready = setup;
        next_cur.resp.pslverr = 1'b0;
        next_cur.resp.prdata = (setup && !i_pwrite) ? rd : i2c_regs_pkg::ZERO_WORD;

        next_cur.irq = |(cur.status[5:0] & cur.mask[5:0]);
        if (cur.status[i2c_regs_pkg::ST_ADDRESSED] && cur.mask[6]) begin
            next_cur.irq = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cur <= '0;
            cur.status <= i2c_regs_pkg::STATUS_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_prdata = cur.resp.prdata;
    assign o_pready = cur.resp.pready;
    assign o_pslverr = cur.resp.pslverr;
    assign o_irq = cur.irq;
    assign o_addr_match = cur.addr_match;
    assign o_mode = cur.mode;
    assign o_tx_data = cur.tx_data;
endmodule // i2c_ctrl_register_bank

// ------------------------------------------------------------
// Byte-lane merge of one writable register
// ------------------------------------------------------------
module i2c_lane_merge #(
    parameter int WIDTH = 32
) (
    input wire logic [WIDTH-1:0] i_old,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_strb,
    output logic [WIDTH-1:0] o_merged
);
    logic [31:0] lanes;

    always_comb begin
        lanes = {{8{i_strb[3]}}, {8{i_strb[2]}}, {8{i_strb[1]}}, {8{i_strb[0]}}};
        o_merged = (i_old & ~lanes[WIDTH-1:0]) | (i_wdata[WIDTH-1:0] & lanes[WIDTH-1:0]);
    end
endmodule // i2c_lane_merge

// ===== bench/i2c_bank_sva.sv
// Purpose: Port checker for the I2C register bank
// Assumes: Mask writes use all byte strobes
// Notes: Mask and read address are shadowed from the bus
`timescale 1ns/100ps
module i2c_bank_sva (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire i2c_regs_pkg::event_t i_event,
    input wire logic i_addr_valid,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_addr_match,
    input wire logic o_irq
);
    logic [6:0] mask;
    logic rd_q;
    logic [7:0] addr_q;
    always_ff @(posedge i_clock) begin
        rd_q <= i_psel && !i_penable && !i_pwrite;
        addr_q <= i_paddr;
        if (i_srst)
            mask <= 7'h00;
        else if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == 8'h04)
            mask <= i_pwdata[6:0];
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    a_ready_next: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    a_ready_once: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    a_gap_zero: assert property (o_pready && rd_q && addr_q == 8'h40 |-> o_prdata == 32'h0)
        else $error("unmapped read not zero");
    a_addr_rsvd: assert property (o_pready && rd_q && addr_q == 8'h00 |-> o_prdata[31:10] == 22'h0)
        else $error("address reserved bits set");
    a_mask_rsvd: assert property (o_pready && rd_q && addr_q == 8'h04 |-> o_prdata[31:7] == 25'h0)
        else $error("mask reserved bits set");
    a_stat_rsvd: assert property (o_pready && rd_q && addr_q == 8'h08 |->
        o_prdata[31:15] == 17'h0 && o_prdata[7:6] == 2'h0)
        else $error("status reserved bits set");
    a_irq_blocked: assert property (mask == 7'h00 |=> !o_irq)
        else $error("irq with mask clear");
    a_irq_raise: assert property (i_event.arbitration_lost ##1 mask[0] |=> o_irq)
        else $error("irq missing");
    a_match_cause: assert property (o_addr_match |-> $past(i_addr_valid))
        else $error("match without address");
endmodule // i2c_bank_sva
bind i2c_ctrl_register_bank i2c_bank_sva i_sva (.i_clock(i_clock), .i_srst(i_srst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_event(i_event), .i_addr_valid(i_addr_valid),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_addr_match(o_addr_match), .o_irq(o_irq));

// ===== bench/i2c_engine_model.sv
// Purpose: Bus engine stand-in driving events, levels and addresses
// Assumes: Every pulse lasts one clock
// Notes: Shift-empty level held high
`timescale 1ns/100ps
module i2c_engine_model (
    input wire logic i_clock,
    input wire logic i_match,
    output i2c_regs_pkg::event_t o_event,
    output i2c_regs_pkg::level_t o_level,
    output logic o_addr_valid,
    output logic [9:0] o_rx_addr
);
    initial begin
        o_event = '0;
        o_level = 4'h4;
        o_addr_valid = 1'h0;
        o_rx_addr = 10'h000;
    end
    task automatic fire(input logic [8:0] ev);
        @(posedge i_clock);
        o_event <= ev;
        @(posedge i_clock);
        o_event <= '0;
    endtask
    task automatic send_addr(input logic [9:0] a, output logic hit);
        @(posedge i_clock);
        o_addr_valid <= 1'h1;
        o_rx_addr <= a;
        @(posedge i_clock);
        o_addr_valid <= 1'h0;
        o_rx_addr <= ~a;
        @(posedge i_clock);
        hit = i_match;
    endtask
endmodule // i2c_engine_model

// ===== bench/testbench.sv
// Purpose: Register-level test of the I2C register bank
// Assumes: Zero wait-state APB
// Notes: Bus engine played by i2c_engine_model
`timescale 1ns/100ps
module testbench;
    logic clock = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic pready, pslverr, av, match, irq, hit;
    logic [7:0] paddr = 8'h00;
    logic [7:0] rxb = 8'h00;
    logic [3:0] pstrb = 4'hf;
    logic rxv = 1'h0;
    logic [9:0] rxa;
    logic [31:0] pwdata = 32'h0, prdata, mode, txd, rdat;
    i2c_regs_pkg::event_t ev;
    i2c_regs_pkg::level_t lv;
    int mismatches = 0, check_count = 0;
    initial begin
        forever #5 clock = ~clock;
    end
    i2c_engine_model i_i2c_engine_model (.i_clock(clock), .i_match(match), .o_event(ev),
        .o_level(lv), .o_addr_valid(av), .o_rx_addr(rxa));
    i2c_ctrl_register_bank i_i2c_ctrl_register_bank (.i_clock(clock), .i_srst(srst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_event(ev), .i_level(lv), .i_addr_valid(av),
        .i_rx_addr(rxa), .i_rx_byte(rxb), .i_rx_byte_valid(rxv), .i_pin_in(8'h5a),
        .o_addr_match(match), .o_irq(irq), .o_mode(mode), .o_tx_data(txd));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1) begin
            mismatches++;
            end_sim();
        end
        rdat = prdata;
    endtask
    task automatic idle;
        psel <= 1'h0;
        penable <= 1'h0;
        repeat (2) @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'h0, a, 32'h0);
        check(rdat, exp);
        check({31'h0, pslverr}, 32'h0);
    endtask
    task automatic addr(input logic [9:0] a, input logic exp);
        i_i2c_engine_model.send_addr(a, hit);
        check({31'h0, hit}, {31'h0, exp});
    endtask
    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'h0;
        rd(8'h08, 32'h0000_0410);
        rd(8'h04, 32'h0000_0000);
        rd(8'h00, 32'h0000_0000);
        xfer(1'h1, 8'h00, 32'hffff_ffff);
        xfer(1'h1, 8'h04, 32'hffff_ffff);
        rd(8'h00, 32'h0000_03ff);
        rd(8'h04, 32'h0000_007f);
        rd(8'h40, 32'h0000_0000);
        idle();
        check({31'h0, irq}, 32'h1);
        $display("reset and reserved test done");
        xfer(1'h1, 8'h08, 32'hffff_ffff);
        rd(8'h08, 32'h0000_0400);
        idle();
        check({31'h0, irq}, 32'h0);
        i_i2c_engine_model.fire(9'h1ff);
        rd(8'h08, 32'h0000_743f);
        xfer(1'h1, 8'h08, 32'h0000_0000);
        rd(8'h08, 32'h0000_743f);
        xfer(1'h1, 8'h08, 32'h0000_0001);
        rd(8'h08, 32'h0000_743e);
        for (int i = 0; i < 7; i++) begin
            xfer(1'h1, 8'h04, 32'h1 << i);
            idle();
            check({31'h0, irq}, {31'h0, (i > 0 && i < 6)});
        end
        xfer(1'h1, 8'h04, 32'h0000_0001);
        idle();
        i_i2c_engine_model.fire(9'h001);
        idle();
        check({31'h0, irq}, 32'h1);
        $display("status and interrupt test done");
        xfer(1'h1, 8'h00, 32'h0000_03a5);
        idle();
        addr(10'h025, 1'h1);
        addr(10'h026, 1'h0);
        xfer(1'h1, 8'h24, 32'h0000_0100);
        xfer(1'h1, 8'h20, 32'h0000_00c3);
        idle();
        check(mode, 32'h0000_0100);
        check(txd, 32'h0000_00c3);
        xfer(1'h1, 8'h04, 32'h0000_0040);
        idle();
        check({31'h0, irq}, 32'h0);
        addr(10'h025, 1'h0);
        addr(10'h3a5, 1'h1);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h1);
        rd(8'h50, 32'h0000_005a);
        idle();
        rxb <= 8'h3c;
        rxv <= 1'h1;
        @(posedge clock);
        rxv <= 1'h0;
        rd(8'h18, 32'h0000_003c);
        pstrb <= 4'h1;
        xfer(1'h1, 8'h00, 32'h0000_0000);
        pstrb <= 4'hf;
        rd(8'h00, 32'h0000_0300);
        idle();
        $display("address and map test done");
        end_sim();
    end
endmodule // testbench
